// >>> design/asgo_defs.vh
// register offsets, field positions and reset values for the front-end setup bank
`ifndef ASGO_DEFS_VH
`define ASGO_DEFS_VH

// byte offsets on the register bus
`define ASGO_OFF_LINE_MODE      8'h00
`define ASGO_OFF_SAMPLE_DETECT  8'h04
`define ASGO_OFF_SEL_DISABLE    8'h08
`define ASGO_OFF_RED_OFFSET     8'h0C
`define ASGO_OFF_GREEN_OFFSET   8'h10
`define ASGO_OFF_BLUE_OFFSET    8'h14
`define ASGO_OFF_ALL_OFFSET     8'h18
`define ASGO_OFF_RED_GAIN       8'h1C
`define ASGO_OFF_GREEN_GAIN     8'h20
`define ASGO_OFF_BLUE_GAIN      8'h24
`define ASGO_OFF_ALL_GAIN       8'h28
`define ASGO_OFF_POWER_CTRL     8'h2C
`define ASGO_OFF_STATUS         8'h30

// line mode / colour setup fields
`define ASGO_LINE_SEQ_BIT       0
`define ASGO_AUTOCYCLE_BIT      1
`define ASGO_FORCE_MUX_BIT      2
`define ASGO_CLAMP_INT_BIT      3
`define ASGO_INT_COLOUR_LSB     4
`define ASGO_FORCED_SEL_LSB     6

// sample detect fields
`define ASGO_DETECT_EN_BIT      0
`define ASGO_DELAY_LSB          1
`define ASGO_POLARITY_BIT       4

// power control register: selective power-down enable in bit 0
`define ASGO_SELECTIVE_POWERDOWN_ENABLE_BIT          0

// colour codes
`define ASGO_COLOUR_RED         2'h0
`define ASGO_COLOUR_GREEN       2'h1
`define ASGO_COLOUR_BLUE        2'h2
`define ASGO_COLOUR_RSVD        2'h3

`define ASGO_RESET_BYTE         8'h00
`define ASGO_RESET_DELAY        3'h0

// axi response codes
`define ASGO_RESP_OKAY          2'h0
`define ASGO_RESP_SLVERR        2'h2

`endif

// >>> design/asgo_regs.v
// setup, offset and gain register bank with sample-pulse edge detector
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "asgo_defs.vh"

module asgo_regs (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        video_sample_pin,
	input  wire        clamp_or_cycle_pin,
	output reg         timing_sample_pulse,
	output reg         clamp_enable,
	output reg         colour_cycle_pulse,
	output reg         single_channel_flag,
	output reg  [1:0]  single_channel_flag_channel_select,
	output reg  [1:0]  internal_colour_select,
	output reg  [1:0]  forced_input_select,
	output reg         force_mux_enable,
	output reg  [3:0]  cell_disable,
	output reg  [23:0] offset_codes,
	output reg  [23:0] gain_codes
);

	////////////////////////////////////////////////////////////////////////
	// register map, one aligned word each, byte in bits 7:0
	//   00 line mode and colour setup
	//      bit 0   line sequential mode
	//      bit 1   autocycle pin select
	//      bit 2   force mux enable, only in line mode
	//      bit 3   internal clamp enable, only with autocycle
	//      bits 5:4 internal colour select
	//      bits 7:6 forced input select
	//   04 sample pulse detect setup
	//      bit 0   detect enable
	//      bits 3:1 delay in clock periods
	//      bit 4   edge polarity, 1 rising, 0 falling
	//      bits 7:5 read as zero
	//   08 selective disable mask
	//      bit 0   red sampling and gain stage
	//      bit 1   green sampling and gain stage
	//      bit 2   blue sampling and gain stage
	//      bit 3   converter
	//      bits 7:4 read as zero
	//   0C 10 14 red, green, blue offset codes
	//   18 broadcast offset, loads all three
	//   1C 20 24 red, green, blue gain codes
	//   28 broadcast gain, loads all three
	//   2C power control, bit 0 selective powerdown
	//   30 live status, read only
	//      bits 3:0 effective cell disables
	//      bit 4   clamp enable as driven
	//      bit 5   single channel flag
	//   anything else answers with an error
	//
	// bus timing
	//   address and data held in any order
	//   register written the edge after both held
	//   response raised at that same edge
	//   read data registered at the edge the address is taken
	//   one write and one read in flight at most
	//
	// gain codes
	//   analogue gain is 208 over (283 minus code)
	//   code zero gives the lowest gain
	//   codes leave on output ports one cycle late
	//
	// line sequential mode
	//   single_channel_flag operation and red channel forced
	//   green and blue stages powered down
	//   with autocycle the shared pin steps colours
	//   and the clamp then follows the internal bit
	//
	// sample pulse path
	//   detect off: pin level one cycle late
	//   detect on: one pulse per qualifying edge
	//   pulse arrives delay plus one cycles after
	//   the edge is first seen on the clock
	//   delay and polarity unused with detect off
	//
	// limitations
	//   only byte lane 0 of the write strobe is used
	//   reserved colour codes are driven as red
	//   broadcast reads return the last value sent
	////////////////////////////////////////////////////////////////////////
	// register storage
	reg [7:0] line_mode_colour_setup;
	reg [7:0] sample_pulse_detect_setup;
	reg [7:0] selective_disable_setup;
	reg [7:0] power_ctrl;
	reg [7:0] offset_code [0:2];
	reg [7:0] gain_code   [0:2];
	reg [7:0] all_offset_broadcast;
	reg [7:0] all_gain_broadcast;

	// write channel capture, address and data may arrive in either order
	reg        aw_held;
	reg [7:0]  aw_addr;
	reg        w_held;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	wire       do_write;
	wire [7:0] wr_byte;
	wire       wr_lane0;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write      = aw_held && w_held && !s_axi_bvalid;
	assign wr_byte       = w_data[7:0];
	// all fields are eight bits wide, so only lane 0 matters
	assign wr_lane0      = w_strb[0];

	// address decode for the write side
	reg wr_known;
	always @* begin
		case (aw_addr)
			`ASGO_OFF_LINE_MODE, `ASGO_OFF_SAMPLE_DETECT, `ASGO_OFF_SEL_DISABLE,
			`ASGO_OFF_RED_OFFSET, `ASGO_OFF_GREEN_OFFSET, `ASGO_OFF_BLUE_OFFSET,
			`ASGO_OFF_ALL_OFFSET, `ASGO_OFF_RED_GAIN, `ASGO_OFF_GREEN_GAIN,
			`ASGO_OFF_BLUE_GAIN, `ASGO_OFF_ALL_GAIN, `ASGO_OFF_POWER_CTRL,
			`ASGO_OFF_STATUS: wr_known = 1'b1;
			default: wr_known = 1'b0;
		endcase
	end

	// write handshake and response
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			aw_addr      <= 8'h00;
			w_held       <= 1'b0;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `ASGO_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? `ASGO_RESP_OKAY : `ASGO_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// setup registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			line_mode_colour_setup    <= `ASGO_RESET_BYTE;
			sample_pulse_detect_setup <= `ASGO_RESET_BYTE;
			selective_disable_setup   <= `ASGO_RESET_BYTE;
			power_ctrl                <= `ASGO_RESET_BYTE;
		end else if (do_write && wr_lane0) begin
			case (aw_addr)
				`ASGO_OFF_LINE_MODE:     line_mode_colour_setup    <= wr_byte;
				`ASGO_OFF_SAMPLE_DETECT: sample_pulse_detect_setup <= {3'b000, wr_byte[4:0]};
				`ASGO_OFF_SEL_DISABLE:   selective_disable_setup   <= {4'h0, wr_byte[3:0]};
				`ASGO_OFF_POWER_CTRL:    power_ctrl                <= {7'h00, wr_byte[0]};
				default: ;
			endcase
		end
	end

	// per-channel offset and gain; a broadcast hits all three at one edge
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : g_chan
			always @(posedge aclk) begin
				if (!aresetn) begin
					offset_code[ch] <= `ASGO_RESET_BYTE;
					gain_code[ch]   <= `ASGO_RESET_BYTE;
				end else if (do_write && wr_lane0) begin
					if (aw_addr == `ASGO_OFF_ALL_OFFSET ||
					    aw_addr == `ASGO_OFF_RED_OFFSET + 8'h04 * ch)
						offset_code[ch] <= wr_byte;
					if (aw_addr == `ASGO_OFF_ALL_GAIN ||
					    aw_addr == `ASGO_OFF_RED_GAIN + 8'h04 * ch)
						gain_code[ch] <= wr_byte;
				end
			end
			// gain = 208/(283-code) is set in the analogue stage from this code
			always @(posedge aclk) begin
				if (!aresetn) begin
					offset_codes[8*ch+7 -: 8] <= `ASGO_RESET_BYTE;
					gain_codes[8*ch+7 -: 8]   <= `ASGO_RESET_BYTE;
				end else begin
					offset_codes[8*ch+7 -: 8] <= offset_code[ch];
					gain_codes[8*ch+7 -: 8]   <= gain_code[ch];
				end
			end
		end
	endgenerate

	// broadcast locations read back the last value written there
	always @(posedge aclk) begin
		if (!aresetn) begin
			all_offset_broadcast <= `ASGO_RESET_BYTE;
			all_gain_broadcast   <= `ASGO_RESET_BYTE;
		end else if (do_write && wr_lane0) begin
			if (aw_addr == `ASGO_OFF_ALL_OFFSET)
				all_offset_broadcast <= wr_byte;
			if (aw_addr == `ASGO_OFF_ALL_GAIN)
				all_gain_broadcast <= wr_byte;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// field views
	wire       line_sequential_mode       = line_mode_colour_setup[`ASGO_LINE_SEQ_BIT];
	wire       autocycle_pin_select       = line_mode_colour_setup[`ASGO_AUTOCYCLE_BIT];
	wire       force_mux_bit              = line_mode_colour_setup[`ASGO_FORCE_MUX_BIT];
	wire       internal_clamp_enable      = line_mode_colour_setup[`ASGO_CLAMP_INT_BIT];
	wire [1:0] int_colour_field           = line_mode_colour_setup[`ASGO_INT_COLOUR_LSB +: 2];
	wire [1:0] forced_field               = line_mode_colour_setup[`ASGO_FORCED_SEL_LSB +: 2];
	wire       sample_pulse_detect_enable = sample_pulse_detect_setup[`ASGO_DETECT_EN_BIT];
	wire [2:0] sample_pulse_delay         = sample_pulse_detect_setup[`ASGO_DELAY_LSB +: 3];
	wire       sample_edge_polarity       = sample_pulse_detect_setup[`ASGO_POLARITY_BIT];
	wire       selective_powerdown_enable = power_ctrl[`ASGO_SELECTIVE_POWERDOWN_ENABLE_BIT];
	wire [3:0] selective_disable_mask     = selective_disable_setup[3:0];
	wire       auto_mode                  = line_sequential_mode && autocycle_pin_select;

	// colour, clamp and power controls; reserved code 11 is held at red
	// so an illegal write cannot route a nonexistent channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			clamp_enable           <= 1'b0;
			colour_cycle_pulse     <= 1'b0;
			single_channel_flag    <= 1'b0;
			single_channel_flag_channel_select    <= `ASGO_COLOUR_RED;
			internal_colour_select <= `ASGO_COLOUR_RED;
			forced_input_select    <= `ASGO_COLOUR_RED;
			force_mux_enable       <= 1'b0;
			cell_disable           <= 4'h0;
		end else begin
			// pin clamps unless autocycle owns it
			clamp_enable <= auto_mode ? internal_clamp_enable : clamp_or_cycle_pin;
			colour_cycle_pulse <= auto_mode && clamp_or_cycle_pin;
			single_channel_flag <= line_sequential_mode;
			single_channel_flag_channel_select <= `ASGO_COLOUR_RED;
			internal_colour_select <= (int_colour_field == `ASGO_COLOUR_RSVD) ?
				`ASGO_COLOUR_RED : int_colour_field;
			forced_input_select <= (forced_field == `ASGO_COLOUR_RSVD) ?
				`ASGO_COLOUR_RED : forced_field;
			force_mux_enable <= line_sequential_mode && force_mux_bit;
			// bit0 red, bit1 green, bit2 blue, bit3 converter
			cell_disable <= (selective_powerdown_enable ? selective_disable_mask : 4'h0) |
				{1'b0, line_sequential_mode, line_sequential_mode, 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sample-pulse edge detector with delay line
	reg       pin_last;
	reg [7:0] delay_line;
	wire      edge_seen;

	assign edge_seen = sample_edge_polarity ? (video_sample_pin && !pin_last) :
		(!video_sample_pin && pin_last);

	// delay_line[k] is the edge seen k+1 cycles ago
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_last   <= 1'b0;
			delay_line <= 8'h00;
		end else begin
			pin_last   <= video_sample_pin;
			delay_line <= {delay_line[6:0], edge_seen};
		end
	end

	// zero delay issues one cycle after the edge, shared latency with bypass
	wire delayed_pulse = (sample_pulse_delay == `ASGO_RESET_DELAY) ? edge_seen :
		delay_line[sample_pulse_delay - 3'd1];

	always @(posedge aclk) begin
		if (!aresetn)
			timing_sample_pulse <= 1'b0;
		else if (sample_pulse_detect_enable)
			timing_sample_pulse <= delayed_pulse;
		else
			timing_sample_pulse <= video_sample_pin;
	end

	////////////////////////////////////////////////////////////////////////
	// read side
	reg [7:0] rd_byte;
	reg       rd_known;
	always @* begin
		rd_known = 1'b1;
		case ({s_axi_araddr[7:2], 2'b00})
			`ASGO_OFF_LINE_MODE:     rd_byte = line_mode_colour_setup;
			`ASGO_OFF_SAMPLE_DETECT: rd_byte = sample_pulse_detect_setup;
			`ASGO_OFF_SEL_DISABLE:   rd_byte = selective_disable_setup;
			`ASGO_OFF_RED_OFFSET:    rd_byte = offset_code[0];
			`ASGO_OFF_GREEN_OFFSET:  rd_byte = offset_code[1];
			`ASGO_OFF_BLUE_OFFSET:   rd_byte = offset_code[2];
			`ASGO_OFF_ALL_OFFSET:    rd_byte = all_offset_broadcast;
			`ASGO_OFF_RED_GAIN:      rd_byte = gain_code[0];
			`ASGO_OFF_GREEN_GAIN:    rd_byte = gain_code[1];
			`ASGO_OFF_BLUE_GAIN:     rd_byte = gain_code[2];
			`ASGO_OFF_ALL_GAIN:      rd_byte = all_gain_broadcast;
			`ASGO_OFF_POWER_CTRL:    rd_byte = power_ctrl;
			// live state: effective cell disables, clamp and single_channel_flag
			`ASGO_OFF_STATUS:        rd_byte = {2'b00, single_channel_flag, clamp_enable, cell_disable};
			default: begin
				rd_byte  = 8'h00;
				rd_known = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `ASGO_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h000000, rd_byte};
			s_axi_rresp  <= rd_known ? `ASGO_RESP_OKAY : `ASGO_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// >>> tb/asgo_regs_assertions.sv
// port-level checker for the setup, offset and gain bank
`timescale 1ns/1ps
`default_nettype none
module asgo_regs_assertions (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        clamp_or_cycle_pin,
	input wire logic        clamp_enable,
	input wire logic        colour_cycle_pulse,
	input wire logic        single_channel_flag,
	input wire logic [1:0]  single_channel_flag_channel_select,
	input wire logic [1:0]  internal_colour_select,
	input wire logic [1:0]  forced_input_select,
	input wire logic [3:0]  cell_disable,
	input wire logic [23:0] offset_codes
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// mode flag lags its register, so wait two cycles out of line mode
	sequence s_no_line;
		!single_channel_flag [*2];
	endsequence
	a_clamp_pass: assert property (s_no_line |-> clamp_enable == $past(clamp_or_cycle_pin))
		else $error("clamp not following pin");
	a_cycle_gated: assert property (s_no_line |-> !colour_cycle_pulse)
		else $error("colour cycle outside line mode");
	a_single_channel_flag_red: assert property (single_channel_flag |-> single_channel_flag_channel_select == 2'h0 && cell_disable[2:1] == 2'h3)
		else $error("line mode not forcing single_channel_flag red");
	a_colour_legal: assert property (internal_colour_select != 2'h3)
		else $error("reserved colour code driven");
	a_forced_legal: assert property (forced_input_select != 2'h3)
		else $error("reserved forced input driven");
	a_bcast_same: assert property ($changed(offset_codes[7:0]) && $changed(offset_codes[15:8])
		|-> offset_codes[7:0] == offset_codes[15:8] && offset_codes[7:0] == offset_codes[23:16])
		else $error("broadcast offsets differ");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while busy");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("error read with data");
endmodule
bind asgo_regs asgo_regs_assertions u_asgo_regs_assertions (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rresp, .s_axi_rdata, .clamp_or_cycle_pin,
	.clamp_enable, .colour_cycle_pulse, .single_channel_flag, .single_channel_flag_channel_select, .internal_colour_select,
	.forced_input_select, .cell_disable, .offset_codes);
`default_nettype wire

// >>> tb/asgo_ctrl_model.sv
// scanner controller model driving the sample and clamp pins
`timescale 1ns/1ps
`default_nettype none
module asgo_ctrl_model (
	input wire logic aclk,
	output var logic video_sample_pin,
	output var logic clamp_or_cycle_pin
);
	initial begin
		video_sample_pin = 1'b0;
		clamp_or_cycle_pin = 1'b0;
	end
	// pins move just after an edge, like the controller's own flops
	task automatic set_pins(input logic v, input logic c);
		@(posedge aclk);
		video_sample_pin <= v;
		clamp_or_cycle_pin <= c;
	endtask
endmodule
`default_nettype wire

// >>> tb/test_asgo_regs.sv
// self-checking bench for the setup, offset and gain bank
`timescale 1ns/1ps
`default_nettype none
`include "asgo_defs.vh"
module test_asgo_regs;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, video_sample_pin, clamp_or_cycle_pin;
	logic        timing_sample_pulse, clamp_enable, colour_cycle_pulse, single_channel_flag, force_mux_enable;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, cell_disable;
	logic [1:0]  s_axi_bresp, s_axi_rresp, single_channel_flag_channel_select, internal_colour_select, forced_input_select;
	logic [23:0] offset_codes, gain_codes;
	int          err_count, comparisons, cyc, n;
	asgo_regs u_asgo_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .video_sample_pin,
		.clamp_or_cycle_pin, .timing_sample_pulse, .clamp_enable, .colour_cycle_pulse, .single_channel_flag,
		.single_channel_flag_channel_select, .internal_colour_select, .forced_input_select, .force_mux_enable, .cell_disable,
		.offset_codes, .gain_codes);
	asgo_ctrl_model u_asgo_ctrl_model (.aclk, .video_sample_pin, .clamp_or_cycle_pin);
	always #5 aclk = ~aclk;
	// hang guard, far above the fewer than a thousand cycles the tests need
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic settle;
		repeat (3) @(posedge aclk);
		#1;
	endtask
	// handshake signals read right after the edge still hold pre-edge values
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int t;
		@(posedge aclk);
		t = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(er, s_axi_bresp, "bresp");
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
		int t;
		@(posedge aclk);
		t = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk({24'h000000, ed}, s_axi_rdata, "rdata");
		chk(er, s_axi_rresp, "rresp");
	endtask
	task automatic meas(output int m);
		m = 0;
		for (int i = 1; i <= 12 && m == 0; i++) begin
			@(posedge aclk);
			#1;
			if (timing_sample_pulse === 1'b1) m = i;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int a = 0; a <= 'h30; a += 4) rd(a[7:0], 8'h00, `ASGO_RESP_OKAY);
		chk(0, offset_codes, "offset codes at reset");
		chk(0, gain_codes, "gain codes at reset");
		rd(8'h34, 8'h00, `ASGO_RESP_SLVERR);
		wr(8'h34, 8'hFF, `ASGO_RESP_SLVERR);
		$display("reset test done");
	endtask
	task automatic t_codes(input logic [7:0] b, input bit g);
		wr(b, 8'h11, `ASGO_RESP_OKAY);
		wr(b + 8'h04, 8'h22, `ASGO_RESP_OKAY);
		wr(b + 8'h08, 8'h33, `ASGO_RESP_OKAY);
		settle;
		chk(24'h332211, g ? gain_codes : offset_codes, "channel codes");
		wr(b + 8'h0C, 8'hA5, `ASGO_RESP_OKAY);
		settle;
		chk(24'hA5A5A5, g ? gain_codes : offset_codes, "broadcast codes");
		for (int i = 0; i < 16; i += 4) rd(b + i[7:0], 8'hA5, `ASGO_RESP_OKAY);
		$display("code test done");
	endtask
	task automatic t_line;
		for (int k = 0; k < 4; k++) begin
			wr(`ASGO_OFF_LINE_MODE, {k[1:0], k[1:0], 4'h5}, `ASGO_RESP_OKAY);
			settle;
			chk((k == 3) ? 0 : k, internal_colour_select, "colour select");
			chk((k == 3) ? 0 : k, forced_input_select, "forced select");
			chk(8'h8D, {single_channel_flag, single_channel_flag_channel_select, cell_disable, force_mux_enable}, "line");
			rd(`ASGO_OFF_LINE_MODE, {k[1:0], k[1:0], 4'h5}, `ASGO_RESP_OKAY);
		end
		$display("line mode test done");
	endtask
	task automatic t_clamp;
		wr(`ASGO_OFF_LINE_MODE, 8'h0B, `ASGO_RESP_OKAY);
		u_asgo_ctrl_model.set_pins(1'b0, 1'b1);
		settle;
		chk(2'h3, {clamp_enable, colour_cycle_pulse}, "autocycle pin");
		wr(`ASGO_OFF_LINE_MODE, 8'h03, `ASGO_RESP_OKAY);
		settle;
		chk(0, clamp_enable, "internal clamp off");
		wr(`ASGO_OFF_LINE_MODE, 8'h00, `ASGO_RESP_OKAY);
		settle;
		chk(2'h2, {clamp_enable, colour_cycle_pulse}, "pin clamp");
		u_asgo_ctrl_model.set_pins(1'b0, 1'b0);
		$display("clamp test done");
	endtask
	task automatic t_mask;
		wr(`ASGO_OFF_SEL_DISABLE, 8'h0F, `ASGO_RESP_OKAY);
		settle;
		chk(0, cell_disable, "mask without powerdown");
		wr(`ASGO_OFF_POWER_CTRL, 8'h01, `ASGO_RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			wr(`ASGO_OFF_SEL_DISABLE, 8'h01 << i, `ASGO_RESP_OKAY);
			settle;
			chk(4'h1 << i, cell_disable, "cell disable");
		end
		wr(`ASGO_OFF_POWER_CTRL, 8'h00, `ASGO_RESP_OKAY);
		$display("mask test done");
	endtask
	task automatic t_detect;
		wr(`ASGO_OFF_SAMPLE_DETECT, 8'h1E, `ASGO_RESP_OKAY);
		u_asgo_ctrl_model.set_pins(1'b1, 1'b0);
		meas(n);
		chk(1, n, "pass-through delay");
		settle;
		chk(1, timing_sample_pulse, "pass-through level");
		u_asgo_ctrl_model.set_pins(1'b0, 1'b0);
		for (int p = 0; p < 2; p++) begin
			for (int d = 0; d < 8; d++) begin
				wr(`ASGO_OFF_SAMPLE_DETECT, {3'h0, p[0], d[2:0], 1'b1}, `ASGO_RESP_OKAY);
				u_asgo_ctrl_model.set_pins(p[0], 1'b0);
				repeat (12) @(posedge aclk);
				u_asgo_ctrl_model.set_pins(!p[0], 1'b0);
				meas(n);
				chk(0, n, "wrong edge");
				u_asgo_ctrl_model.set_pins(p[0], 1'b0);
				meas(n);
				chk(d + 1, n, "pulse delay");
				@(posedge aclk);
				#1;
				chk(0, timing_sample_pulse, "pulse width");
			end
		end
		$display("detect test done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		{err_count, comparisons, cyc} = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_codes(`ASGO_OFF_RED_OFFSET, 1'b0);
		t_codes(`ASGO_OFF_RED_GAIN, 1'b1);
		t_line;
		t_clamp;
		t_mask;
		t_detect;
		give_verdict;
	end
endmodule
`default_nettype wire
